// ### inc/vms_pkg.sv
// Constants of the VCO mode and seed register bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
//------------------------------------------------------------
//------------------------------------------------------------
package vms_pkg;
  localparam int unsigned vms_reg_w = 24;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [7:0] vms_idx_modes = 8'h17;
  localparam logic [7:0] vms_idx_bias = 8'h18;
  localparam logic [7:0] vms_idx_cal = 8'h19;
  localparam logic [7:0] vms_idx_seed = 8'h1a;
  localparam logic [23:0] vms_rst_modes = 24'h0001ab;
  localparam logic [23:0] vms_rst_bias = 24'h0054c1;
  localparam logic [23:0] vms_rst_cal = 24'h000aaa;
  localparam logic [23:0] vms_rst_seed = 24'hb29d0b;
  localparam logic [23:0] vms_cal_working = 24'h000ab2;
  // Modes register field positions
  localparam int unsigned vms_b_master = 0;
  localparam int unsigned vms_b_vco = 1;
  localparam int unsigned vms_b_ext_buf = 2;
  localparam int unsigned vms_b_pll_buf = 3;
  localparam int unsigned vms_b_pri_en = 4;
  localparam int unsigned vms_b_sec_en = 5;
  localparam int unsigned vms_b_ext_in = 6;
  localparam int unsigned vms_b_mute = 7;
  localparam int unsigned vms_b_pri_se = 8;
  localparam int unsigned vms_b_sec_se = 9;
  localparam int unsigned vms_b_cp_sel = 11;
  // Bias register field positions
  localparam int unsigned vms_b_bias0 = 19;
  localparam int unsigned vms_b_bias1 = 20;
endpackage

// ### testbench/testbench.sv
// Self-checking bench of the VCO mode and seed register bank.
// Assumes vms_pkg, vms_regs and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vms_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, er;
  logic chip_en = 0, pll_locked = 0, exact_freq_mode = 1, auto_seed_en = 1;
  logic phase_sync_en = 1, freq_change = 0, pslverr, phase_step, phase_load;
  logic subsys_en, vco_en, ext_vco_buf_en, pll_buf_en, ext_input_en;
  logic primary_osc_output_en, secondary_osc_output_en, primary_osc_pos_pin;
  logic primary_osc_neg_pin, secondary_osc_pos_pin, secondary_osc_neg_pin;
  logic pump_output_one, pump_output_two;
  logic [1:0] ext_input_bias;
  logic [11:0] paddr = 0;
  logic [23:0] cal_word, phase_word, rv [4];
  logic [31:0] pwdata = 0, prdata, rd, wv [4];
  int err_count = 0, cmp_count = 0, seed = 32'hb94ce012;
  vms_regs DUT (.*);
  always #20 pclk = ~pclk;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Expected decoded controls from a modes value, chip enable and lock
  function automatic logic [12:0] exp_out(logic [23:0] m, logic ce, lk);
    logic s, p, q;
    s = m[0] & ce;
    p = s & m[4] & (!m[7] | lk);
    q = s & m[5] & (!m[7] | lk);
    return {s, s & m[1], s & m[2], s & m[3], s & m[6], p, q, p & !m[8], p,
      q & !m[9], q, s & !m[11], s & m[11]};
  endfunction
  task automatic print_verdict;
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
  initial begin
    rv = '{vms_rst_modes, vms_rst_bias, vms_rst_cal, vms_rst_seed};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'h05c + 12'(4 * i), 0);
      chk("rst", rd, 32'(rv[i]));
      wv[i] = i == 2 ? 32'(vms_cal_working) : $random(seed);
      apb(1, 12'h05c + 12'(4 * i), wv[i]);
      apb(0, 12'h05c + 12'(4 * i), 0);
      chk("rdbk", rd, 32'(wv[i][23:0]));
    end
    chk("cal", 32'(cal_word), 32'(vms_cal_working));
    chk("bias", 32'(ext_input_bias), 32'(wv[1][20:19]));
    chk("phase", 32'(phase_word), 32'(wv[3][23:0]));
    apb(0, 12'h070, 0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    $display("Register test done");
    for (int n = 0; n < 24; n++) begin
      wv[0] = n == 0 ? 32'hfff : $random(seed);
      apb(1, 12'h05c, wv[0]);
      chip_en <= 1'($random(seed)) | n == 0;
      pll_locked <= 1'($random(seed));
      @(posedge pclk);
      #1;
      chk("decode", 32'({subsys_en, vco_en, ext_vco_buf_en, pll_buf_en,
        ext_input_en, primary_osc_output_en, secondary_osc_output_en,
        primary_osc_pos_pin, primary_osc_neg_pin, secondary_osc_pos_pin,
        secondary_osc_neg_pin, pump_output_one, pump_output_two}),
        32'(exp_out(wv[0][23:0], chip_en, pll_locked)));
    end
    $display("Decode test done");
    exact_freq_mode <= 0;
    auto_seed_en <= 0;
    wv[3] = $random(seed);
    apb(1, 12'h068, wv[3]);
    freq_change <= 1;
    @(posedge pclk);
    freq_change <= 0;
    #1;
    chk("load", 32'(phase_load), 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk("reload", 32'(phase_word), 32'(wv[3][23:0]));
    $display("Reload test done");
    auto_seed_en <= 1;
    chip_en <= 0;
    rv[3] = wv[3][23:0];
    wv[3] = $random(seed);
    apb(1, 12'h068, wv[3]);
    @(posedge pclk);
    #1;
    chk("hold", 32'(phase_word), 32'(rv[3]));
    chk("noload", 32'(phase_load), 32'h0);
    chip_en <= 1;
    @(posedge pclk);
    #1;
    chk("start", 32'(phase_word), 32'(wv[3][23:0]));
    chk("startld", 32'(phase_load), 32'h1);
    $display("Auto seed test done");
    print_verdict;
  end
endmodule
`default_nettype wire

// ### testbench/vms_regs_checker.sv
// Port assertions for the VCO mode and seed register bank.
// Assumes binding to vms_regs.
`timescale 1ns/10ps
`default_nettype none
module vms_regs_checker (
  // Bus and status
  input wire logic pclk, presetn, psel, penable, pwrite, chip_en,
  input wire logic [11:0] paddr,
  input wire logic exact_freq_mode, auto_seed_en, phase_sync_en, freq_change,
  // Decoded outputs
  input wire logic subsys_en, primary_osc_output_en, pump_output_one,
  input wire logic primary_osc_pos_pin, primary_osc_neg_pin, pump_output_two,
  input wire logic secondary_osc_pos_pin, secondary_osc_neg_pin,
  input wire logic phase_load, phase_step
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ce; !chip_en |-> !subsys_en; endproperty
  a_ce: assert property (p_ce) else $error("ce gate");
  property p_lo; primary_osc_output_en |-> subsys_en; endproperty
  a_lo: assert property (p_lo) else $error("output gate");
  property p_s1; primary_osc_pos_pin |-> primary_osc_neg_pin; endproperty
  a_s1: assert property (p_s1) else $error("primary pins");
  property p_s2; secondary_osc_pos_pin |-> secondary_osc_neg_pin; endproperty
  a_s2: assert property (p_s2) else $error("secondary pins");
  property p_cp; subsys_en == (pump_output_one ^ pump_output_two); endproperty
  a_cp: assert property (p_cp) else $error("pump route");
  property p_sd; exact_freq_mode && psel && penable && pwrite &&
    paddr == 12'h068 |-> ##[1:2] phase_load; endproperty
  a_sd: assert property (p_sd) else $error("seed load");
  property p_rl; !exact_freq_mode && !auto_seed_en && freq_change
    |-> ##[1:2] phase_load; endproperty
  a_rl: assert property (p_rl) else $error("reload");
  property p_sy; exact_freq_mode && phase_sync_en && $rose(chip_en)
    |-> ##[1:2] phase_step; endproperty
  a_sy: assert property (p_sy) else $error("sync step");
endmodule
bind vms_regs vms_regs_checker u_chk (.*);
`default_nettype wire

// ### verilog/vms_regs.sv
// VCO mode and seed register bank with APB slave and decoded controls.
// Assumes lock, mode and frequency-change inputs are synchronous to pclk.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vms_regs
  import vms_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip status
  input wire logic chip_en,
  input wire logic pll_locked,
  input wire logic exact_freq_mode,
  input wire logic auto_seed_en,
  input wire logic phase_sync_en,
  input wire logic freq_change,
  // Analog controls
  output logic subsys_en,
  output logic vco_en,
  output logic ext_vco_buf_en,
  output logic pll_buf_en,
  output logic ext_input_en,
  output logic primary_osc_output_en,
  output logic secondary_osc_output_en,
  output logic primary_osc_pos_pin,
  output logic primary_osc_neg_pin,
  output logic secondary_osc_pos_pin,
  output logic secondary_osc_neg_pin,
  output logic pump_output_one,
  output logic pump_output_two,
  output logic [1:0] ext_input_bias,
  output logic [23:0] cal_word,
  // Phase control
  output logic [23:0] phase_word,
  output logic phase_load,
  output logic phase_step
);
  //------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------
  logic [23:0] modes_q;
  logic [23:0] bias_q;
  logic [23:0] cal_q;
  logic [23:0] seed_q;
  logic chip_en_q;
  logic [23:0] phase_q;
  logic load_q;
  logic step_q;
  logic [9:0] idx;
  logic aligned;
  logic hit;
  logic access;
  logic wr;
  logic wr_modes;
  logic wr_bias;
  logic wr_cal;
  logic wr_seed;

  // True when a word index selects the given register
  function automatic logic reg_sel(input logic [9:0] i,
      input logic [7:0] r);
    reg_sel = (i == {2'b00, r});
  endfunction

  function automatic logic map_hit(input logic [9:0] i);
    map_hit = reg_sel(i, vms_idx_modes) || reg_sel(i, vms_idx_bias)
      || reg_sel(i, vms_idx_cal) || reg_sel(i, vms_idx_seed);
  endfunction

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit = map_hit(idx) && aligned;
  assign access = psel && penable;
  // No wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign wr = access && pwrite && hit;
  assign wr_modes = wr && reg_sel(idx, vms_idx_modes);
  assign wr_bias = wr && reg_sel(idx, vms_idx_bias);
  assign wr_cal = wr && reg_sel(idx, vms_idx_cal);
  assign wr_seed = wr && reg_sel(idx, vms_idx_seed);

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  // Reserved bits are stored as written, so a rewrite replaces their defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modes_q <= vms_rst_modes;
    end else if (wr_modes) begin
      modes_q <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_q <= vms_rst_bias;
    end else if (wr_bias) begin
      bias_q <= pwdata[23:0];
    end
  end

  // Calibration keeps its default until software rewrites it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= vms_rst_cal;
    end else if (wr_cal) begin
      cal_q <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_q <= vms_rst_seed;
    end else if (wr_seed) begin
      seed_q <= pwdata[23:0];
    end
  end

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  logic [23:0] rd_word;

  // Unmapped and misaligned reads return zero
  always_comb begin
    rd_word = 24'h000000;
    if (!aligned) begin
      rd_word = 24'h000000;
    end else if (reg_sel(idx, vms_idx_modes)) begin
      rd_word = modes_q;
    end else if (reg_sel(idx, vms_idx_bias)) begin
      rd_word = bias_q;
    end else if (reg_sel(idx, vms_idx_cal)) begin
      rd_word = cal_q;
    end else if (reg_sel(idx, vms_idx_seed)) begin
      rd_word = seed_q;
    end
  end

  // Loaded in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {8'h00, rd_word};
    end
  end

  //------------------------------------------------------------
  // Mode decode
  //------------------------------------------------------------
  logic unmuted;
  logic pri_on;
  logic sec_on;
  assign subsys_en = modes_q[vms_b_master] && chip_en;
  assign vco_en = subsys_en && modes_q[vms_b_vco];
  assign ext_vco_buf_en = subsys_en && modes_q[vms_b_ext_buf];
  assign ext_input_en = subsys_en && modes_q[vms_b_ext_in];
  assign pll_buf_en = subsys_en && modes_q[vms_b_pll_buf];

  //------------------------------------------------------------
  // Output buffers
  //------------------------------------------------------------
  // Mute releases as soon as lock is reported
  assign unmuted = !modes_q[vms_b_mute] || pll_locked;
  assign pri_on = subsys_en && modes_q[vms_b_pri_en] && unmuted;
  assign sec_on = subsys_en && modes_q[vms_b_sec_en] && unmuted;
  assign primary_osc_output_en = pri_on;
  assign secondary_osc_output_en = sec_on;

  //------------------------------------------------------------
  // Output pins
  //------------------------------------------------------------
  // Single-ended mode uses the negative pin only
  assign primary_osc_neg_pin = pri_on;
  assign primary_osc_pos_pin = pri_on && !modes_q[vms_b_pri_se];
  assign secondary_osc_neg_pin = sec_on;
  assign secondary_osc_pos_pin = sec_on && !modes_q[vms_b_sec_se];

  //------------------------------------------------------------
  // Charge pump
  //------------------------------------------------------------
  assign pump_output_one = subsys_en && !modes_q[vms_b_cp_sel];
  assign pump_output_two = subsys_en && modes_q[vms_b_cp_sel];

  //------------------------------------------------------------
  // Bias and calibration
  //------------------------------------------------------------
  assign ext_input_bias = {bias_q[vms_b_bias1], bias_q[vms_b_bias0]};
  assign cal_word = cal_q;

  //------------------------------------------------------------
  // Seed phase control
  //------------------------------------------------------------
  // phase_word is seed; phase = 2*pi*phase_word/2^24
  logic sync_edge;
  logic take_seed;
  logic load_d;
  logic step_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_en_q <= 1'b0;
    end else begin
      chip_en_q <= chip_en;
    end
  end
  assign sync_edge = chip_en && !chip_en_q;

  //------------------------------------------------------------
  // Phase event selection
  //------------------------------------------------------------
  always_comb begin
    take_seed = 1'b0;
    load_d = 1'b0;
    step_d = 1'b0;
    if (exact_freq_mode) begin
      take_seed = 1'b1;
      load_d = wr_seed;
      step_d = phase_sync_en && sync_edge;
    end else if (auto_seed_en) begin
      take_seed = sync_edge;
      load_d = sync_edge;
    end else begin
      take_seed = freq_change || sync_edge;
      load_d = freq_change || sync_edge;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= vms_rst_seed;
    end else if (take_seed) begin
      phase_q <= seed_q;
    end
  end

  // One-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 1'b0;
    end else begin
      step_q <= step_d;
    end
  end
  assign phase_word = phase_q;
  assign phase_load = load_q;
  assign phase_step = step_q;
endmodule
`default_nettype wire
